/* core/wasm_pkg.sv */
// What this block does
// - auto-scale lowers 10/15 mA inputs to 2 mA
// - comparator inputs use the comparator level
// - ADC inputs pick threshold by input number
// - filter 00 reduces on next cycle
// - filter 01/10/11 needs 2/3/4 stable cycles
// - restore after same count once open
// - only 10/15 mA inputs, continuous mode only
// - side disable bit keeps current unchanged
// - thermal warning or shutdown raises interrupt
// - sample supply at each cycle end when enabled, none while a conversion is in flight
// - extra conversion, 10-bit result stored
// - span bit 0 selects 9 V range
// - span bit 1 selects 30 V range
// - first result after enable always interrupts
// - first status is baseline, then crossings only
// - comparison results readable as status bits
// - cross flag set while supply event pending
// - edge select rising, falling or both
// - edge select 0 blocks flag and pin, except on the first result after enable
// - pin mask gates pin, status still updates
// - supply measurement off after reset
// - reading event status clears it, releases pin
package wasm_pkg;
   localparam int          N_IN        = 24;
   localparam int          CW          = 10;
   // word indexes of the register map
   localparam logic [5:0]  IX_CTRL     = 6'h00;
   localparam logic [5:0]  IX_EVEN     = 6'h01;
   localparam logic [5:0]  IX_STAT     = 6'h02;
   localparam logic [5:0]  IX_MISC     = 6'h03;
   localparam logic [5:0]  IX_ANA      = 6'h04;
   localparam logic [5:0]  IX_HIMASK   = 6'h05;
   localparam logic [5:0]  IX_SRCMASK  = 6'h06;
   localparam logic [5:0]  IX_ADCMASK  = 6'h07;
   localparam logic [5:0]  IX_MAPLO    = 6'h08;
   localparam logic [5:0]  IX_MAPHI    = 6'h09;
   localparam logic [5:0]  IX_SCALED   = 6'h0A;
   localparam logic [1:0]  LVL_GRP     = 2'h1;
   // control word fields
   localparam int          F_SUP_ON    = 0;
   localparam int          F_SPAN      = 1;
   localparam int          F_DBC       = 2;
   localparam int          F_SRC_OFF   = 4;
   localparam int          F_SNK_OFF   = 5;
   localparam int          F_CONT      = 6;
   localparam logic [31:0] CTRL_MASK   = 32'h0000007F;
   // event enable fields
   localparam int          F_SEL_A     = 0;
   localparam int          F_SEL_B     = 2;
   localparam int          F_PMASK_A   = 4;
   localparam int          F_PMASK_B   = 5;
   localparam logic [31:0] EVEN_MASK   = 32'h0000003F;
   localparam logic [31:0] EVEN_RST    = 32'h00000030;
   localparam logic [31:0] IN_MASK     = 32'h00FFFFFF;
   localparam logic [31:0] MAPLO_MASK  = 32'h3FFFFFFF;
   localparam logic [31:0] MAPHI_MASK  = 32'h0000003F;
   // level table slots
   localparam logic [3:0]  LV_2B       = 4'h8;
   localparam logic [3:0]  LV_3C       = 4'h9;
   localparam logic [3:0]  LV_9        = 4'hA;
   localparam logic [3:0]  LV_CMP      = 4'hB;
   localparam logic [3:0]  LV_S0A      = 4'hC;
   localparam logic [3:0]  LV_S0B      = 4'hD;
   localparam logic [3:0]  LV_S1A      = 4'hE;
   localparam logic [3:0]  LV_S1B      = 4'hF;
   // input number ranges for ADC-mode thresholds
   localparam logic [4:0]  CH_MAP_END  = 5'h0C;
   localparam logic [4:0]  CH_2B_END   = 5'h12;
   localparam logic [4:0]  CH_3C_END   = 5'h17;
   // status bit positions
   localparam int          S_EV_A      = 0;
   localparam int          S_EV_B      = 1;
   localparam int          S_TW        = 2;
   localparam int          S_TSD       = 3;

   typedef struct packed {
      logic          valid;
      logic [4:0]    chan;
      logic [CW-1:0] code;
   } wasm_sample_t;

   typedef enum logic [0:0] {SUP_IDLE, SUP_CONV} wasm_sup_t;
endpackage

/* core/wasm_core.sv */
`timescale 1ns/100ps
module wasm_core (
   // clock and reset
   input  wire logic                   sys_clk_i,
   input  wire logic                   srst_i,
   // avalon-mm slave
   input  wire logic [7:0]             avs_address_i,
   input  wire logic                   avs_read_i,
   input  wire logic                   avs_write_i,
   input  wire logic [31:0]            avs_writedata_i,
   input  wire logic [3:0]             avs_byteenable_i,
   output logic      [31:0]            avs_readdata_o,
   output logic                        avs_waitrequest_o,
   // detection engine
   input  wire wasm_pkg::wasm_sample_t sample_i,
   input  wire logic                   cycle_end_i,
   output logic                        supply_conv_req_o,
   output logic                        supply_span_sel_o,
   input  wire logic                   supply_valid_i,
   input  wire logic [9:0]             supply_code_i,
   output logic      [23:0]            scaled_o,
   // thermal pins
   input  wire logic                   thermal_warning_i,
   input  wire logic                   thermal_shutdown_i,
   // host signalling
   output logic                        int_n_o,
   output logic                        supply_cross_flag_o
);
   function automatic logic [31:0] merge(input logic [31:0] o,
                                         input logic [31:0] w,
                                         input logic [3:0]  be,
                                         input logic [31:0] m);
      logic [31:0] r;
      r = o;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[b*8 +: 8] = w[b*8 +: 8];
         end
      end
      return r & m;
   endfunction

   // hysteresis: at or above upper sets, below lower clears
   function automatic logic next_sup(input logic [9:0] code,
                                     input logic [9:0] lo,
                                     input logic [9:0] hi,
                                     input logic       old);
      if (code >= hi) begin
         return 1'b1;
      end else if (code < lo) begin
         return 1'b0;
      end
      return old;
   endfunction

   function automatic logic edge_hit(input logic [1:0] sel,
                                     input logic       old,
                                     input logic       nxt);
      return (sel[0] & ~old & nxt) | (sel[1] & old & ~nxt);
   endfunction

   logic [31:0]          ctrl;
   logic [31:0]          even;
   logic [31:0]          hi_mask;
   logic [31:0]          src_mask;
   logic [31:0]          adc_mask;
   logic [31:0]          map_lo;
   logic [31:0]          map_hi;
   logic [9:0]           lvl [16];
   logic [3:0]           int_stat;
   logic [9:0]           ana_result;
   logic                 sup_a;
   logic                 sup_b;
   logic                 baseline;
   logic                 en_prev;
   wasm_pkg::wasm_sup_t  sup_st;
   logic                 ack;
   logic [1:0]           tw_sync;
   logic [1:0]           tsd_sync;
   logic                 tw_prev;
   logic                 tsd_prev;
   logic [2:0]           cnt [24];
   logic [23:0]          elig;

   // bus decode
   wire        req    = avs_read_i | avs_write_i;
   wire [5:0]  idx    = avs_address_i[7:2];
   wire        wr_go  = ack & avs_write_i;
   wire        lvl_hit = idx[5:4] == wasm_pkg::LVL_GRP;
   wire [3:0]  lvl_ix = idx[3:0];
   wire [31:0] lvl_new = merge({22'h000000, lvl[lvl_ix]}, avs_writedata_i,
                               avs_byteenable_i, 32'h000003FF);
   wire        rd_stat = ack & avs_read_i & idx == wasm_pkg::IX_STAT;
   assign avs_waitrequest_o = req & ~ack;

   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h00000000;
      if (lvl_hit) begin
         rd_mux = {22'h000000, lvl[lvl_ix]};
      end else begin
         case (idx)
            wasm_pkg::IX_CTRL:    rd_mux = ctrl;
            wasm_pkg::IX_EVEN:    rd_mux = even;
            wasm_pkg::IX_STAT:    rd_mux = {28'h0000000, int_stat};
            wasm_pkg::IX_MISC:    rd_mux = {30'h00000000, sup_b, sup_a};
            wasm_pkg::IX_ANA:     rd_mux = {22'h000000, ana_result};
            wasm_pkg::IX_HIMASK:  rd_mux = hi_mask;
            wasm_pkg::IX_SRCMASK: rd_mux = src_mask;
            wasm_pkg::IX_ADCMASK: rd_mux = adc_mask;
            wasm_pkg::IX_MAPLO:   rd_mux = map_lo;
            wasm_pkg::IX_MAPHI:   rd_mux = map_hi;
            wasm_pkg::IX_SCALED:  rd_mux = {8'h00, scaled_o};
            default:              rd_mux = 32'h00000000;
         endcase
      end
   end

   // control fields
   wire       sup_on  = ctrl[wasm_pkg::F_SUP_ON];
   wire [1:0] dbc     = ctrl[wasm_pkg::F_DBC +: 2];
   wire       src_off = ctrl[wasm_pkg::F_SRC_OFF];
   wire       snk_off = ctrl[wasm_pkg::F_SNK_OFF];
   wire       cont    = ctrl[wasm_pkg::F_CONT];
   wire [1:0] sel_a   = even[wasm_pkg::F_SEL_A +: 2];
   wire [1:0] sel_b   = even[wasm_pkg::F_SEL_B +: 2];
   wire       pmask_a = even[wasm_pkg::F_PMASK_A];
   wire       pmask_b = even[wasm_pkg::F_PMASK_B];
   assign supply_span_sel_o = ctrl[wasm_pkg::F_SPAN];

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         ack            <= 1'b0;
         avs_readdata_o <= 32'h00000000;
         ctrl           <= 32'h00000000;
         even           <= wasm_pkg::EVEN_RST;
         hi_mask        <= 32'h00000000;
         src_mask       <= 32'h00000000;
         adc_mask       <= 32'h00000000;
         map_lo         <= 32'h00000000;
         map_hi         <= 32'h00000000;
         for (int i = 0; i < 16; i++) begin
            lvl[i] <= 10'h000;
         end
      end else begin
         ack <= req & ~ack;
         if (avs_read_i & ~ack) begin
            avs_readdata_o <= rd_mux;
         end
         if (wr_go & lvl_hit) begin
            lvl[lvl_ix] <= lvl_new[9:0];
         end
         if (wr_go) begin
            case (idx)
               wasm_pkg::IX_CTRL:    ctrl <= merge(ctrl, avs_writedata_i,
                  avs_byteenable_i, wasm_pkg::CTRL_MASK);
               wasm_pkg::IX_EVEN:    even <= merge(even, avs_writedata_i,
                  avs_byteenable_i, wasm_pkg::EVEN_MASK);
               wasm_pkg::IX_HIMASK:  hi_mask <= merge(hi_mask,
                  avs_writedata_i, avs_byteenable_i, wasm_pkg::IN_MASK);
               wasm_pkg::IX_SRCMASK: src_mask <= merge(src_mask,
                  avs_writedata_i, avs_byteenable_i, wasm_pkg::IN_MASK);
               wasm_pkg::IX_ADCMASK: adc_mask <= merge(adc_mask,
                  avs_writedata_i, avs_byteenable_i, wasm_pkg::IN_MASK);
               wasm_pkg::IX_MAPLO:   map_lo <= merge(map_lo,
                  avs_writedata_i, avs_byteenable_i, wasm_pkg::MAPLO_MASK);
               wasm_pkg::IX_MAPHI:   map_hi <= merge(map_hi,
                  avs_writedata_i, avs_byteenable_i, wasm_pkg::MAPHI_MASK);
               default: ;
            endcase
         end
      end
   end

   // closure threshold for the sample's input
   wire [4:0]  ch      = sample_i.chan;
   wire [35:0] map_all = {map_hi[5:0], map_lo[29:0]};
   wire [2:0]  map_ix  = map_all[ch*3 +: 3];
   wire [9:0]  thr_adc = (ch < wasm_pkg::CH_MAP_END) ? lvl[{1'b0, map_ix}] :
                         (ch < wasm_pkg::CH_2B_END)  ? lvl[wasm_pkg::LV_2B] :
                         (ch < wasm_pkg::CH_3C_END)  ? lvl[wasm_pkg::LV_3C] :
                                                       lvl[wasm_pkg::LV_9];
   wire [9:0]  thr     = adc_mask[ch] ? thr_adc
                                      : lvl[wasm_pkg::LV_CMP];
   wire        closed  = sample_i.code >= thr;
   wire [2:0]  filt_n  = {1'b0, dbc} + 3'h1;

   always_comb begin
      for (int i = 0; i < wasm_pkg::N_IN; i++) begin
         elig[i] = hi_mask[i] & cont &
                   ~(src_mask[i] ? src_off : snk_off);
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         scaled_o <= 24'h000000;
         for (int i = 0; i < wasm_pkg::N_IN; i++) begin
            cnt[i] <= 3'h0;
         end
      end else begin
         for (int i = 0; i < wasm_pkg::N_IN; i++) begin
            if (!elig[i]) begin
               scaled_o[i] <= 1'b0;
               cnt[i]      <= 3'h0;
            end else if (sample_i.valid && ch == i[4:0]) begin
               if (closed != scaled_o[i]) begin
                  // one counter per input
                  if (cnt[i] + 3'h1 >= filt_n) begin
                     scaled_o[i] <= closed;
                     cnt[i]      <= 3'h0;
                  end else begin
                     cnt[i] <= cnt[i] + 3'h1;
                  end
               end else begin
                  cnt[i] <= 3'h0;
               end
            end
         end
      end
   end

   // supply measurement
   wire sup_done = sup_st == wasm_pkg::SUP_CONV && supply_valid_i;
   wire sa_new   = next_sup(supply_code_i, lvl[wasm_pkg::LV_S0A],
                            lvl[wasm_pkg::LV_S0B], sup_a);
   wire sb_new   = next_sup(supply_code_i, lvl[wasm_pkg::LV_S1A],
                            lvl[wasm_pkg::LV_S1B], sup_b);
   wire ev_a     = sup_done & (baseline | edge_hit(sel_a, sup_a, sa_new));
   wire ev_b     = sup_done & (baseline | edge_hit(sel_b, sup_b, sb_new));
   wire tw_rise  = tw_sync[1] & ~tw_prev;
   wire tsd_rise = tsd_sync[1] & ~tsd_prev;
   wire [3:0] stat_set = {tsd_rise, tw_rise, ev_b, ev_a};
   // clear only what the host saw; a new event wins
   wire [3:0] stat_clr = rd_stat ? avs_readdata_o[3:0] : 4'h0;
   wire [3:0] next_stat = (int_stat & ~stat_clr) | stat_set;
   wire [3:0] pin_gate = {2'b11, pmask_b, pmask_a};

   assign int_n_o = ~|(int_stat & pin_gate);
   assign supply_cross_flag_o = |int_stat[1:0];

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         sup_st            <= wasm_pkg::SUP_IDLE;
         supply_conv_req_o <= 1'b0;
         ana_result        <= 10'h000;
         sup_a             <= 1'b0;
         sup_b             <= 1'b0;
         baseline          <= 1'b0;
         en_prev           <= 1'b0;
         int_stat          <= 4'h0;
         tw_sync           <= 2'b00;
         tsd_sync          <= 2'b00;
         tw_prev           <= 1'b0;
         tsd_prev          <= 1'b0;
      end else begin
         tw_sync           <= {tw_sync[0], thermal_warning_i};
         tsd_sync          <= {tsd_sync[0], thermal_shutdown_i};
         tw_prev           <= tw_sync[1];
         tsd_prev          <= tsd_sync[1];
         en_prev           <= sup_on;
         int_stat          <= next_stat;
         supply_conv_req_o <= 1'b0;
         if (sup_on & ~en_prev) begin
            baseline <= 1'b1;
         end else if (sup_done) begin
            baseline <= 1'b0;
         end
         case (sup_st)
            wasm_pkg::SUP_IDLE: begin
               if (cycle_end_i & sup_on) begin
                  supply_conv_req_o <= 1'b1;
                  sup_st            <= wasm_pkg::SUP_CONV;
               end
            end
            wasm_pkg::SUP_CONV: begin
               if (supply_valid_i) begin
                  ana_result <= supply_code_i;
                  sup_a      <= sa_new;
                  sup_b      <= sb_new;
                  sup_st     <= wasm_pkg::SUP_IDLE;
               end
            end
            default: sup_st <= wasm_pkg::SUP_IDLE;
         endcase
      end
   end

   // checks
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (srst_i);

   wire hit0 = sample_i.valid && elig[ch] && closed && !scaled_o[ch] &&
               dbc == 2'b00;

   property p_reset_off;
      $past(srst_i) |-> !sup_on;
   endproperty
   property p_conv_req;
      sup_st == wasm_pkg::SUP_IDLE && cycle_end_i && sup_on
         |=> supply_conv_req_o ##1 !supply_conv_req_o;
   endproperty
   property p_result;
      sup_done |=> ana_result == $past(supply_code_i);
   endproperty
   property p_first;
      sup_done && baseline |=> int_stat[1:0] == 2'b11 && supply_cross_flag_o;
   endproperty
   property p_off_sel;
      sup_done && !baseline && sel_a == 2'b00 && !int_stat[0]
         |=> !int_stat[0];
   endproperty
   property p_mask;
      int_stat[3:1] == 3'b000 && !pmask_a |-> int_n_o;
   endproperty
   property p_thermal;
      $rose(thermal_warning_i) ##1 thermal_warning_i[*2]
         |-> ##[1:2] (int_stat[2] && !int_n_o);
   endproperty
   property p_rdclr;
      rd_stat && stat_set == 4'h0 && avs_readdata_o[3:0] == int_stat
         |=> int_stat == 4'h0 && int_n_o;
   endproperty
   property p_fast;
      hit0 |=> scaled_o[$past(ch)];
   endproperty
   property p_poll;
      !cont [*2] |-> scaled_o == 24'h000000;
   endproperty

   a_reset_off: assert property (p_reset_off) else $error("sup on");
   a_conv_req: assert property (p_conv_req) else $error("no req");
   a_result: assert property (p_result) else $error("bad result");
   a_first: assert property (p_first) else $error("no baseline");
   a_off_sel: assert property (p_off_sel) else $error("sel off");
   a_mask: assert property (p_mask) else $error("pin unmasked");
   a_thermal: assert property (p_thermal) else $error("no tw");
   a_rdclr: assert property (p_rdclr) else $error("no clear");
   a_fast: assert property (p_fast) else $error("slow scale");
   a_poll: assert property (p_poll) else $error("scaled in poll");

   c_base: cover property (sup_done && baseline);
   c_scale: cover property ($rose(scaled_o[0]));
   c_tsd: cover property (tsd_rise);
endmodule

/* test/wasm_adc_model.sv */
`timescale 1ns/100ps
module wasm_adc_model (
   // clock and reset
   input  wire logic       sys_clk_i,
   input  wire logic       srst_i,
   // conversion link
   input  wire logic       conv_req_i,
   input  wire logic [3:0] lat_i,
   input  wire logic [9:0] level_i,
   output logic            valid_o,
   output logic [9:0]      code_o
);
   logic [3:0] cnt;
   logic       busy;

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         busy    <= 1'b0;
         cnt     <= 4'h0;
         valid_o <= 1'b0;
         code_o  <= 10'h000;
      end else if (busy && cnt == 4'h0) begin
         busy    <= 1'b0;
         valid_o <= 1'b1;
         // saturated readings arrive as full-scale codes
         code_o  <= level_i;
      end else begin
         // code lines toggle outside the result pulse
         valid_o <= 1'b0;
         code_o  <= ~code_o;
         if (conv_req_i && !busy) begin // one conversion in flight
            busy <= 1'b1;
            cnt  <= lat_i;
         end else if (busy) begin
            cnt <= cnt - 4'h1;
         end
      end
   end
endmodule

/* test/wetting_autoscale_supply_monitor_tb.sv */
`timescale 1ns/100ps
module wetting_autoscale_supply_monitor_tb;
   logic                   sys_clk_i;
   logic                   srst_i;
   logic [7:0]             avs_address_i;
   logic                   avs_read_i;
   logic                   avs_write_i;
   logic [31:0]            avs_writedata_i;
   logic [3:0]             avs_byteenable_i;
   logic [31:0]            avs_readdata_o;
   logic                   avs_waitrequest_o;
   wasm_pkg::wasm_sample_t sample_i;
   logic                   cycle_end_i;
   logic                   supply_conv_req_o;
   logic                   supply_span_sel_o;
   logic                   supply_valid_i;
   logic [9:0]             supply_code_i;
   logic [23:0]            scaled_o;
   logic                   thermal_warning_i;
   logic                   thermal_shutdown_i;
   logic                   int_n_o;
   logic                   supply_cross_flag_o;
   logic [3:0]             adc_lat;
   logic [9:0]             adc_level;
   logic [31:0]            rdata;
   int                     err_total;
   int                     check_count;

   wasm_core wasm_core_inst (.sys_clk_i, .srst_i, .avs_address_i, .avs_read_i,
      .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
      .avs_waitrequest_o, .sample_i, .cycle_end_i, .supply_conv_req_o,
      .supply_span_sel_o, .supply_valid_i, .supply_code_i, .scaled_o,
      .thermal_warning_i, .thermal_shutdown_i, .int_n_o,
      .supply_cross_flag_o);

   wasm_adc_model wasm_adc_model_inst (.sys_clk_i(sys_clk_i),
      .srst_i(srst_i), .conv_req_i(supply_conv_req_o), .lat_i(adc_lat),
      .level_i(adc_level), .valid_o(supply_valid_i),
      .code_o(supply_code_i));

   initial begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic tally_and_finish;
      $display("checks=%0d mismatches=%0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // one avalon transfer held until waitrequest is seen low at an edge
   task automatic av_xfer(input logic wr, input logic [7:0] a,
                          input logic [31:0] d);
      @(posedge sys_clk_i);
      avs_address_i   <= a;
      avs_writedata_i <= d;
      avs_read_i      <= !wr;
      avs_write_i     <= wr;
      do begin
         @(posedge sys_clk_i);
      end while (avs_waitrequest_o);
      rdata = avs_readdata_o;
      avs_read_i  <= 1'b0;
      avs_write_i <= 1'b0;
      @(negedge sys_clk_i);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      av_xfer(1'b1, a, d);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      av_xfer(1'b0, a, 32'h00000000);
      chk(rdata, exp);
   endtask

   // end of detection cycle, waits for any conversion to finish
   task automatic conv(input logic [9:0] code, input logic exp_req);
      logic seen;
      seen = 1'b0;
      @(posedge sys_clk_i);
      adc_level   <= code;
      cycle_end_i <= 1'b1;
      @(posedge sys_clk_i);
      cycle_end_i <= 1'b0;
      repeat (40) begin
         @(negedge sys_clk_i);
         seen = seen | supply_conv_req_o;
      end
      chk(32'(seen), 32'(exp_req));
   endtask

   task automatic smp(input logic [4:0] ch, input logic [9:0] code);
      @(posedge sys_clk_i);
      sample_i <= '{1'b1, ch, code};
      @(posedge sys_clk_i);
      sample_i.valid <= 1'b0;
      @(posedge sys_clk_i);
      @(negedge sys_clk_i);
   endtask

   task automatic t_reset;
      chk(32'(int_n_o), 32'h1);
      rd_chk(8'h00, 32'h00000000);
      rd_chk(8'h04, wasm_pkg::EVEN_RST);
      rd_chk(8'hFC, 32'h00000000);
      conv(10'h3FF, 1'b0);
      $display("test reset done");
   endtask

   task automatic t_supply;
      wr(8'h70, 32'h00000100);
      wr(8'h74, 32'h00000200);
      wr(8'h78, 32'h00000300);
      wr(8'h7C, 32'h00000380);
      wr(8'h00, 32'h00000001);
      chk(32'(supply_span_sel_o), 32'h0);
      conv(10'h050, 1'b1);
      chk(32'(int_n_o), 32'h0);
      chk(32'(supply_cross_flag_o), 32'h1);
      rd_chk(8'h10, 32'h00000050);
      rd_chk(8'h0C, 32'h00000000);
      rd_chk(8'h08, 32'h00000003);
      chk(32'(int_n_o), 32'h1);
      chk(32'(supply_cross_flag_o), 32'h0);
      wr(8'h00, 32'h00000003);
      chk(32'(supply_span_sel_o), 32'h1);
      conv(10'h3FF, 1'b1);
      rd_chk(8'h10, 32'h000003FF);
      rd_chk(8'h0C, 32'h00000003);
      rd_chk(8'h08, 32'h00000000);
      chk(32'(int_n_o), 32'h1);
      $display("test supply done");
   endtask

   task automatic t_edges;
      logic [31:0] cfg [8] = '{32'h31, 32'h31, 32'h32, 32'h33, 32'h33,
                               32'h22, 32'h22, 32'h3C};
      logic [9:0]  code [8] = '{10'h050, 10'h250, 10'h050, 10'h250,
                                10'h050, 10'h250, 10'h050, 10'h3FF};
      logic [31:0] st [8] = '{32'h0, 32'h1, 32'h1, 32'h1, 32'h1, 32'h0,
                              32'h1, 32'h2};
      logic [31:0] pin [8] = '{32'h1, 32'h0, 32'h0, 32'h0, 32'h0, 32'h1,
                               32'h1, 32'h0};
      logic [31:0] ms [8] = '{32'h0, 32'h1, 32'h0, 32'h1, 32'h0, 32'h1,
                              32'h0, 32'h3};
      for (int i = 0; i < 8; i++) begin
         adc_lat <= i[0] ? 4'hC : 4'h1;
         wr(8'h04, cfg[i]);
         conv(code[i], 1'b1);
         chk(32'(int_n_o), pin[i]);
         rd_chk(8'h0C, ms[i]);
         rd_chk(8'h08, st[i]);
      end
      $display("test edges done");
   endtask

   task automatic t_scale;
      wr(8'h14, 32'h00001007);
      wr(8'h18, 32'h00000001);
      wr(8'h1C, 32'h00001000);
      wr(8'h6C, 32'h00000200);
      wr(8'h60, 32'h00000180);
      wr(8'h00, 32'h00000040);
      smp(5'd0, 10'h250);
      chk(32'(scaled_o[0]), 32'h1);
      rd_chk(8'h28, 32'h00000001);
      smp(5'd0, 10'h1FF);
      chk(32'(scaled_o[0]), 32'h0);
      smp(5'd12, 10'h1A0);
      chk(32'(scaled_o[12]), 32'h1);
      smp(5'd3, 10'h300);
      chk(32'(scaled_o[3]), 32'h0);
      wr(8'h00, 32'h0000004C);
      repeat (3) begin
         smp(5'd1, 10'h250);
         chk(32'(scaled_o[1]), 32'h0);
      end
      smp(5'd2, 10'h250);
      smp(5'd1, 10'h250);
      chk(32'(scaled_o[1]), 32'h1);
      chk(32'(scaled_o[2]), 32'h0);
      repeat (3) begin
         smp(5'd1, 10'h100);
         chk(32'(scaled_o[1]), 32'h1);
      end
      smp(5'd1, 10'h100);
      chk(32'(scaled_o[1]), 32'h0);
      wr(8'h00, 32'h00000050);
      smp(5'd0, 10'h250);
      chk(32'(scaled_o[0]), 32'h0);
      smp(5'd1, 10'h250);
      chk(32'(scaled_o[1]), 32'h1);
      wr(8'h00, 32'h00000044);
      smp(5'd12, 10'h100);
      chk(32'(scaled_o[12]), 32'h1);
      smp(5'd12, 10'h100);
      chk(32'(scaled_o[12]), 32'h0);
      wr(8'h00, 32'h00000000);
      smp(5'd2, 10'h250);
      chk(32'(scaled_o[2]), 32'h0);
      $display("test scale done");
   endtask

   task automatic t_thermal;
      for (int i = 0; i < 2; i++) begin
         @(posedge sys_clk_i);
         thermal_warning_i  <= (i == 0);
         thermal_shutdown_i <= (i == 1);
         repeat (4) @(posedge sys_clk_i);
         @(negedge sys_clk_i);
         chk(32'(int_n_o), 32'h0);
         rd_chk(8'h08, (i == 0) ? 32'h4 : 32'h8);
         chk(32'(int_n_o), 32'h1);
      end
      $display("test thermal done");
   endtask

   initial begin
      err_total          = 0;
      check_count        = 0;
      srst_i             = 1'b1;
      avs_address_i      = 8'h00;
      avs_read_i         = 1'b0;
      avs_write_i        = 1'b0;
      avs_writedata_i    = 32'h00000000;
      avs_byteenable_i   = 4'hF;
      sample_i           = '0;
      cycle_end_i        = 1'b0;
      thermal_warning_i  = 1'b0;
      thermal_shutdown_i = 1'b0;
      adc_lat            = 4'h1;
      adc_level          = 10'h000;
      repeat (12) @(posedge sys_clk_i);
      srst_i <= 1'b0;
      @(negedge sys_clk_i);
      t_reset();
      t_supply();
      t_edges();
      t_scale();
      t_thermal();
      tally_and_finish();
   end

   initial begin
      repeat (20000) @(posedge sys_clk_i);
      err_total++;
      $display("watchdog expired");
      tally_and_finish();
   end
endmodule
